//--- dpla_arbiter.sv
// dual-port dram arbiter: page select, local lock, collision override
//
// Contract
// - write-only 8-bit page register at 0eeh
// - reset loads page register with zero
// - low nibble is page; 4..15 reserved
// - dual-port access lands in selected page
// - lock bit low reserves memory for local
// - collision with outgoing cycle grants remote anyway
// - outgoing cycle waits until remote finishes
// - unlocked memory is granted to remote
// - local lock independent of bus lock
// - remote bus lock blocks cpu and dma
// - cpu may assert bus lock outgoing
// - alias steps are one megabyte
// - protected mode has no window translation
// - region bounds at 64 kbyte resolution
// - alias sum wraps modulo 16 mbytes
// - start above end disables dual-port
// - own outgoing cycles never loop back
`timescale 1ns/1ps
`include "dpla_regs.svh"

module dpla_arbiter
   import dpla_pkg::*;
(
   // clock and reset
   input  wire logic         i_core_clk,
   input  wire logic         i_rst,
   // local i/o write port
   input  wire logic         i_io_wr,
   input  wire logic [7:0]   i_io_addr,
   input  wire logic [7:0]   i_io_wdata,
   // parallel_port_unit port c bit 1, low locks
   input  wire logic         i_ppu_lock_n,
   // jumper straps, static
   input  wire dpla_straps_t i_straps,
   // remote multibus master
   input  wire logic         i_mb_req,
   input  wire logic [23:0]  i_mb_addr,
   input  wire logic         i_mb_lock,
   output logic              o_mb_gnt,
   // local cpu and local_dma_engine dual-port requests
   input  wire logic         i_cpu_req,
   input  wire logic [23:0]  i_cpu_addr,
   input  wire logic         i_dma_req,
   input  wire logic [23:0]  i_dma_addr,
   output logic              o_cpu_gnt,
   output logic              o_dma_gnt,
   // outgoing multibus cycle of this board
   input  wire logic         i_out_req,
   input  wire logic [23:0]  i_out_addr,
   input  wire logic         i_out_lock_req,
   output logic              o_out_go,
   output logic              o_out_refused,
   output logic              o_out_lock,
   output logic              o_out_window,
   // shared dram path
   output dpla_dram_t        o_dram
);

   // page register state
   logic [3:0]  page_reg;
   logic [3:0]  page_next;
   logic        page_wr;

   // arbiter state
   dpla_state_t state_reg;
   dpla_state_t state_next;
   logic        hold_out_reg;
   logic        hold_out_next;
   logic        rlock_reg;
   logic        rlock_next;
   logic        out_prev_reg;
   logic        out_prev_next;
   logic        dma_own_reg;
   logic        dma_own_next;
   dpla_dram_t  dram_reg;
   dpla_dram_t  dram_next;

   // decode results
   logic        mb_hit;
   logic [23:0] mb_offset;
   logic        self_hit;
   logic        local_lock;
   logic        out_start;
   logic        collision;
   logic        remote_ok;
   logic        local_block;
   logic [7:0]  out_blk;

   // ----- page select register -----

   // decode write to 0eeh, nothing readable
   assign page_wr = i_io_wr && (i_io_addr == `DPLA_PAGE_IO_ADDR);

   always_comb begin
      page_next = page_reg;
      if (page_wr) begin
         page_next = i_io_wdata[`DPLA_PAGE_MSB:`DPLA_PAGE_LSB];
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         page_reg <= `DPLA_PAGE_RESET;
      end else begin
         page_reg <= page_next;
      end
   end

   // ----- address decode -----

   // incoming remote address: region hit and aliased offset
   dpla_decode u_mb_dec (
      .i_addr        (i_mb_addr),
      .i_start_bound (i_straps.start_bound),
      .i_end_bound   (i_straps.end_bound),
      .i_alias_code  (i_straps.alias_code),
      .o_hit         (mb_hit),
      .o_offset      (mb_offset)
   );

   // outgoing address checked against the same region; alias unused
   dpla_decode u_self_dec (
      .i_addr        (i_out_addr),
      .i_start_bound (i_straps.start_bound),
      .i_end_bound   (i_straps.end_bound),
      .i_alias_code  (4'h0),
      .o_hit         (self_hit),
      .o_offset      ()
   );

   // window exists only in real mode
   assign out_blk = i_out_addr[`DPLA_BOUND_MSB:`DPLA_BOUND_LSB];
   assign o_out_window = !i_straps.protected_mode
                         && (out_blk >= i_straps.win_start)
                         && (out_blk <= i_straps.win_end);

   // ----- lock and collision terms -----

   // lock level follows the port bit
   // bus lock plays no part in this term
   assign local_lock = !i_ppu_lock_n;

   // an outgoing cycle starts on the rising edge of its request
   assign out_start = i_out_req && !out_prev_reg;

   // remote request meeting our own outgoing start
   assign collision = i_mb_req && mb_hit && out_start;

   // unlocked: remote wins; locked: only on collision
   assign remote_ok = i_mb_req && mb_hit && (!local_lock || collision);

   // remote holding bus lock keeps cpu and dma out
   assign local_block = rlock_reg && i_mb_lock;

   // ----- outgoing cycle tracking -----

   // a stale hold would stall every later outgoing cycle, so any
   // state other than idle or a live remote grant lets it go
   always_comb begin
      out_prev_next = i_out_req;
      hold_out_next = hold_out_reg;
      case (state_reg)
         DPLA_IDLE: begin
            // park own outgoing cycle on collision
            if (remote_ok) begin
               hold_out_next = collision;
            end
         end
         DPLA_REMOTE: begin
            // remote completed or abandoned its cycle
            if (!i_mb_req) begin
               hold_out_next = 1'b0;
            end
         end
         DPLA_LOCAL: begin
            hold_out_next = 1'b0;
         end
         default: begin
            hold_out_next = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         out_prev_reg <= 1'b0;
         hold_out_reg <= 1'b0;
      end else begin
         out_prev_reg <= out_prev_next;
         hold_out_reg <= hold_out_next;
      end
   end

   // ----- remote bus lock tracking -----

   // armed by a locked remote grant
   // outlives the access while the lock stays high
   always_comb begin
      rlock_next = rlock_reg;
      if (!i_mb_lock) begin
         rlock_next = 1'b0;
      end else if ((state_reg == DPLA_IDLE) && remote_ok) begin
         rlock_next = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rlock_reg <= 1'b0;
      end else begin
         rlock_reg <= rlock_next;
      end
   end

   // ----- arbiter -----

   always_comb begin
      state_next    = state_reg;
      dma_own_next  = dma_own_reg;
      dram_next     = dram_reg;
      dram_next.valid = 1'b0;

      case (state_reg)
         DPLA_IDLE: begin
            if (remote_ok) begin
               state_next = DPLA_REMOTE;
               dram_next.valid  = 1'b1;
               dram_next.remote = 1'b1;
               dram_next.dma    = 1'b0;
               dram_next.addr   = {page_reg, mb_offset};
            end else if (!local_block && i_cpu_req) begin
               state_next   = DPLA_LOCAL;
               dma_own_next = 1'b0;
               dram_next.valid  = 1'b1;
               dram_next.remote = 1'b0;
               dram_next.dma    = 1'b0;
               dram_next.addr   = {page_reg, i_cpu_addr};
            end else if (!local_block && i_dma_req) begin
               state_next   = DPLA_LOCAL;
               dma_own_next = 1'b1;
               dram_next.valid  = 1'b1;
               dram_next.remote = 1'b0;
               dram_next.dma    = 1'b1;
               dram_next.addr   = {page_reg, i_dma_addr};
            end
         end
         DPLA_REMOTE: begin
            // remote completed or abandoned its cycle
            if (!i_mb_req) begin
               state_next = DPLA_IDLE;
            end
         end
         DPLA_LOCAL: begin
            // local access runs to completion before anyone else
            if (dma_own_reg ? !i_dma_req : !i_cpu_req) begin
               state_next = DPLA_IDLE;
            end
         end
         default: begin
            state_next = DPLA_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg    <= DPLA_IDLE;
         dma_own_reg  <= 1'b0;
         dram_reg     <= '0;
      end else begin
         state_reg    <= state_next;
         dma_own_reg  <= dma_own_next;
         dram_reg     <= dram_next;
      end
   end

   // ----- grants and outgoing control -----

   // grants decoded from a single state
   assign o_mb_gnt  = (state_reg == DPLA_REMOTE);
   assign o_cpu_gnt = (state_reg == DPLA_LOCAL) && !dma_own_reg;
   assign o_dma_gnt = (state_reg == DPLA_LOCAL) && dma_own_reg;

   // own region is never reached through the multibus
   assign o_out_refused = i_out_req && self_hit;

   // outgoing cycle waits for the collision to clear
   // the start cycle itself is held too, since the hold flop
   // only rises one edge later
   assign o_out_go = i_out_req && !self_hit && !hold_out_reg
                     && !collision;

   // cpu drives bus lock on its outgoing cycles
   // local lock does not gate it
   assign o_out_lock = i_out_req && i_out_lock_req;

   // dram request comes from a flop, registered on the same edge as the grant
   assign o_dram = dram_reg;

endmodule

//--- dpla_regs.svh
// register offsets, field positions, reset values and decode steps
`ifndef DPLA_REGS_SVH
`define DPLA_REGS_SVH

// local i/o address of the page-select register
`define DPLA_PAGE_IO_ADDR   8'hee
// page number field position and width
`define DPLA_PAGE_LSB       0
`define DPLA_PAGE_MSB       3
// page-select reset value
`define DPLA_PAGE_RESET     4'h0
// highest valid page number; above it is reserved
`define DPLA_PAGE_MAX       4'h3
// alias offset step is 1 mbyte: alias code sits at bit 20
`define DPLA_ALIAS_LSB      20
// region bounds compare at 64 kbyte resolution: bits 23..16
`define DPLA_BOUND_LSB      16
`define DPLA_BOUND_MSB      23
// one 16 mbyte page is 24 address bits
`define DPLA_OFS_W          24
`define DPLA_PHYS_W         28

`endif

//--- dpla_pkg.sv
// types shared by the dual-port page/lock arbiter
package dpla_pkg;

   typedef enum logic [1:0] {
      DPLA_IDLE,
      DPLA_REMOTE,
      DPLA_LOCAL
   } dpla_state_t;

   // static jumper configuration
   typedef struct packed {
      logic [7:0] start_bound;
      logic [7:0] end_bound;
      logic [3:0] alias_code;
      logic       protected_mode;
      logic [7:0] win_start;
      logic [7:0] win_end;
   } dpla_straps_t;

   // one access presented to the shared dram path
   typedef struct packed {
      logic        valid;
      logic        remote;
      logic        dma;
      logic [27:0] addr;
   } dpla_dram_t;

endpackage

//--- dpla_decode.sv
// dual-port region decode and alias translation of a 24-bit address
`timescale 1ns/1ps
`include "dpla_regs.svh"

module dpla_decode
   import dpla_pkg::*;
(
   // address and straps
   input  wire logic [23:0] i_addr,
   input  wire logic [7:0]  i_start_bound,
   input  wire logic [7:0]  i_end_bound,
   input  wire logic [3:0]  i_alias_code,
   // results
   output logic             o_hit,
   output logic [23:0]      o_offset
);

   logic [7:0] blk;
   logic       enabled;

   assign blk = i_addr[`DPLA_BOUND_MSB:`DPLA_BOUND_LSB];

   assign enabled = (i_start_bound <= i_end_bound);

   assign o_hit = enabled && (blk >= i_start_bound) && (blk <= i_end_bound);

   // carry out of bit 23 is dropped, so sums wrap in 16 mbytes
   assign o_offset = i_addr + {i_alias_code, 20'h0_0000};

endmodule

//--- dpla_arbiter_assertions.sv
// assertion checker for the dual-port page/lock arbiter
`timescale 1ns/1ps
module dpla_arbiter_chk
   import dpla_pkg::*;
(
   // clock, reset, lock and straps
   input wire logic         i_core_clk,
   input wire logic         i_rst,
   input wire logic         i_ppu_lock_n,
   input wire dpla_straps_t i_straps,
   // requests, grants and outgoing cycle
   input wire logic         i_mb_req,
   input wire logic [23:0]  i_mb_addr,
   input wire logic         o_mb_gnt,
   input wire logic         o_cpu_gnt,
   input wire logic         o_dma_gnt,
   input wire logic         i_out_req,
   input wire logic [23:0]  i_out_addr,
   input wire logic         i_out_lock_req,
   input wire logic         o_out_go,
   input wire logic         o_out_refused,
   input wire logic         o_out_lock,
   input wire dpla_dram_t   o_dram
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   function automatic logic hit(input logic [23:0] a);
      return i_straps.start_bound <= a[23:16] &&
             a[23:16] <= i_straps.end_bound;
   endfunction
   wire logic idle = !(o_mb_gnt || o_cpu_gnt || o_dma_gnt);
   sequence s_ask;
      idle && i_mb_req && hit(i_mb_addr);
   endsequence
   sequence s_clash;
      s_ask ##0 !i_ppu_lock_n && $rose(i_out_req);
   endsequence
   chk_one_grant: assert property (
      $onehot0({o_mb_gnt, o_cpu_gnt, o_dma_gnt})) else $error("two grants");
   chk_free_grant: assert property (
      s_ask ##0 i_ppu_lock_n |=> o_mb_gnt) else $error("no remote grant");
   chk_lock_holds: assert property (
      s_ask ##0 !i_ppu_lock_n && !$rose(i_out_req) |=> !o_mb_gnt)
      else $error("lock ignored");
   chk_clash_grant: assert property (
      s_clash |=> o_mb_gnt) else $error("clash not granted");
   chk_out_pends: assert property (
      s_clash ##1 i_mb_req [*4] |-> !o_out_go) else $error("out not held");
   chk_bus_lock: assert property (
      o_out_lock == (i_out_req && i_out_lock_req)) else $error("bus lock");
   chk_self_refuse: assert property (
      i_out_req && hit(i_out_addr) |-> o_out_refused && !o_out_go)
      else $error("own region not refused");
   chk_alias_wrap: assert property (
      $rose(o_mb_gnt) |-> o_dram.valid && o_dram.remote &&
      o_dram.addr[23:0] == i_mb_addr + {i_straps.alias_code, 20'h0})
      else $error("dram address");
endmodule

bind dpla_arbiter dpla_arbiter_chk u_chk (.*);

//--- dpla_remote_master.sv
// behavioural remote multibus master facing the arbiter
`timescale 1ns/1ps
module dpla_remote_master (
   // clock and grant
   input  wire logic   i_core_clk,
   input  wire logic   i_mb_gnt,
   // multibus request lines
   output logic        o_mb_req = 1'b0,
   output logic [23:0] o_mb_addr = 24'h0,
   output logic        o_mb_lock = 1'b0
);
   // lock spans the access and three cycles past it
   task automatic access(input logic [23:0] a, input logic lk,
                         input int w, input int h, output logic got);
      int n;
      n = 0;
      got = 1'b0;
      {o_mb_req, o_mb_addr, o_mb_lock} = {1'b1, a, lk};
      // an ungranted cycle is abandoned after w edges
      while (got !== 1'b1 && n < w) begin
         @(posedge i_core_clk);
         got = i_mb_gnt;
         n++;
      end
      if (got === 1'b1) repeat (h) @(posedge i_core_clk);
      #1;
      // released lines show the inverse so stale data never matches
      {o_mb_req, o_mb_addr} = {1'b0, ~a};
      if (lk) repeat (3) @(posedge i_core_clk);
      if (lk) #1;
      o_mb_lock = 1'b0;
   endtask
endmodule

//--- dual_port_page_lock_arbiter_tb.sv
// self-checking bench for the dual-port arbiter
`timescale 1ns/1ps
module dual_port_page_lock_arbiter_tb
   import dpla_pkg::*;
;
   logic         clk = 1'b0, rst = 1'b1, wr = 1'b0, lk_n = 1'b1, got;
   logic         creq = 1'b0, dreq = 1'b0, oreq = 1'b0, olrq = 1'b0;
   logic         mreq, mlk, mgnt, cgnt, dgnt, ogo, oref, olk, owin;
   logic [7:0]   ioa = 8'h0, iod = 8'h0;
   logic [23:0]  oadr = 24'h500000, madr;
   dpla_straps_t st = '{8'h20, 8'h2f, 4'he, 1'b1, 8'h0a, 8'h0c};
   dpla_dram_t   dram, cap;
   int           fails = 0, compares = 0;

   dpla_arbiter i_dut (
      .i_core_clk(clk), .i_rst(rst), .i_io_wr(wr), .i_io_addr(ioa),
      .i_io_wdata(iod), .i_ppu_lock_n(lk_n), .i_straps(st),
      .i_mb_req(mreq), .i_mb_addr(madr), .i_mb_lock(mlk),
      .o_mb_gnt(mgnt), .i_cpu_req(creq), .i_cpu_addr(24'h010000),
      .i_dma_req(dreq), .i_dma_addr(24'h020000), .o_cpu_gnt(cgnt),
      .o_dma_gnt(dgnt), .i_out_req(oreq), .i_out_addr(oadr),
      .i_out_lock_req(olrq), .o_out_go(ogo), .o_out_refused(oref),
      .o_out_lock(olk), .o_out_window(owin), .o_dram(dram));
   dpla_remote_master i_rm (.i_core_clk(clk), .i_mb_gnt(mgnt),
      .o_mb_req(mreq), .o_mb_addr(madr), .o_mb_lock(mlk));

   initial forever #20 clk = ~clk;
   always @(posedge clk) if (dram.valid === 1'b1) cap = dram;

   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         fails++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // strobe stays high across both writes, so it never toggles in a step
   task automatic page_wr(input logic [7:0] d);
      {ioa, iod, wr} = {8'hee, d, 1'b1};
      cyc(1);
      {ioa, iod} = {8'hef, 8'h01};
      cyc(1);
      wr = 1'b0;
   endtask
   task automatic complete_run;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // all tests need about 105 cycles; 5000 means a hang
   initial begin
      #200000;
      fails++;
      complete_run;
   end

   initial begin
      cyc(12);
      rst = 1'b0;
      i_rm.access(24'h2a1234, 1'b0, 8, 1, got);
      chk(cap.addr === 28'h00a1234 && cap.remote === 1'b1,
          "reset page"); // wrap
      cyc(2);
      for (int p = 0; p < 4; p++) begin
         page_wr({4'ha, p[3:0]});
         i_rm.access(24'h2fffff, 1'b0, 8, 1, got);
         chk(cap.addr === {p[3:0], 24'h0fffff}, "page"); // page
         cyc(2);
      end
      $display("end page test");
      i_rm.access(24'h300000, 1'b0, 6, 1, got);
      chk(got === 1'b0, "above end"); // bound
      lk_n = 1'b0;
      cyc(1);
      i_rm.access(24'h200000, 1'b0, 6, 1, got);
      chk(got === 1'b0, "locked"); // reserved
      cyc(1);
      fork
         i_rm.access(24'h200000, 1'b0, 8, 1, got);
         begin
            cyc(3);
            lk_n = 1'b1;
         end
      join
      chk(got === 1'b1, "unlocked"); // granted
      cyc(2);
      $display("end lock test");
      lk_n = 1'b0;
      fork
         i_rm.access(24'h210000, 1'b0, 3, 6, got);
         oreq = 1'b1;
         begin
            cyc(3);
            chk(ogo === 1'b0, "out pending"); // held
         end
      join
      chk(got === 1'b1 && ogo === 1'b0, "clash"); // override
      cyc(1);
      chk(ogo === 1'b1, "out resumes"); // released
      {oreq, lk_n} = 2'b01;
      cyc(2);
      $display("end clash test");
      fork
         i_rm.access(24'h220000, 1'b1, 4, 3, got);
         {creq, dreq} = 2'b11;
      join
      chk(cgnt === 1'b0 && dgnt === 1'b0, "bus lock"); // blocked
      cyc(2);
      chk(cgnt === 1'b1, "cpu after lock"); // freed
      creq = 1'b0;
      cyc(3);
      chk(dgnt === 1'b1 && cap.dma === 1'b1 && cap.addr === 28'h3020000,
          "dma"); // dma
      dreq = 1'b0;
      $display("end bus lock test");
      {oadr, olrq, oreq, lk_n} = {24'h250000, 3'b110};
      cyc(1);
      chk(oref === 1'b1 && ogo === 1'b0 && olk === 1'b1, "own");
      {oadr, lk_n} = {24'h0b0000, 1'b1};
      cyc(1);
      chk(olk === 1'b1 && ogo === 1'b1 && owin === 1'b0, "pm");
      {st.protected_mode, st.alias_code} = 5'h00;
      cyc(1);
      chk(owin === 1'b1, "real window"); // window
      {oreq, olrq} = 2'b00;
      cyc(1);
      i_rm.access(24'h2a0000, 1'b0, 6, 1, got);
      chk(cap.addr === 28'h32a0000, "no alias"); // concat
      {st.start_bound, oadr} = {8'h30, 24'h250000};
      oreq = 1'b1;
      cyc(1);
      chk(oref === 1'b0 && ogo === 1'b1, "disabled refuse"); // off
      i_rm.access(24'h250000, 1'b0, 6, 1, got);
      chk(got === 1'b0, "disabled"); // off
      $display("end outgoing test");
      complete_run;
   end
endmodule
